//--- hdl/cptr_pkg.sv
// Package: register offsets, field positions, reset values and timing constants
package cptr_pkg;
    localparam logic [7:0] CPTR_OFS_VCTRL  = 8'h04;
    localparam logic [7:0] CPTR_OFS_TCTRL  = 8'h05;
    localparam logic [7:0] CPTR_OFS_FAULT  = 8'h09;
    localparam logic [7:0] CPTR_RST_VCTRL  = 8'hb2;
    localparam logic [7:0] CPTR_RST_TCTRL  = 8'h9a;
    localparam int         CPTR_VCODE_HI   = 7;
    localparam int         CPTR_VCODE_LO   = 2;
    localparam int         CPTR_PRE_BIT    = 1;
    localparam int         CPTR_RCH_BIT    = 0;
    localparam int         CPTR_TERM_BIT   = 7;
    localparam int         CPTR_EARLY_BIT  = 6;
    localparam int         CPTR_WD_HI      = 5;
    localparam int         CPTR_WD_LO      = 4;
    localparam int         CPTR_TMR_BIT    = 3;
    localparam int         CPTR_TLIM_HI    = 2;
    localparam int         CPTR_TLIM_LO    = 1;
    localparam int         CPTR_FAULT_HI   = 5;
    localparam int         CPTR_FAULT_LO   = 4;
    localparam logic [1:0] CPTR_FAULT_TMR  = 2'h3;
    localparam int         CPTR_CLK_HZ     = 10000000;
    localparam int         CPTR_TICK_S     = 1;
    localparam int         CPTR_TICK_CYC   = CPTR_CLK_HZ * CPTR_TICK_S;
    localparam int         CPTR_WD_S0      = 40;
    localparam int         CPTR_WD_S1      = 80;
    localparam int         CPTR_WD_S2      = 160;
    localparam int         CPTR_HR_S       = 3600;
    localparam int         CPTR_LIM_H0     = 5;
    localparam int         CPTR_LIM_H1     = 8;
    localparam int         CPTR_LIM_H2     = 12;
    localparam int         CPTR_LIM_H3     = 20;
endpackage

//--- hdl/cptr_sec_counter.sv
`timescale 1ns/1ps
// Seconds counter with clear, enable and half-rate option, compared to a limit
module cptr_sec_counter #(
    parameter int W = 17
) (
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    input  wire logic         tick,
    input  wire logic         run,
    input  wire logic         clear,
    input  wire logic         half,
    input  wire logic [W-1:0] limit,
    output logic              expired
);
    logic [W-1:0] cnt_r;
    logic         phase_r;
    wire          step = tick && run && (!half || phase_r);
    wire          hit  = (cnt_r >= limit);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_r   <= '0;
            phase_r <= 1'b0;
            expired <= 1'b0;
        end else if (clear) begin
            cnt_r   <= '0;
            phase_r <= 1'b0;
            expired <= 1'b0;
        end else begin
            if (tick && run)
                phase_r <= ~phase_r;
            if (step && !hit)
                cnt_r <= cnt_r + 1'b1;
            expired <= run && hit;
        end
    end
endmodule

//--- hdl/cptr_regs.sv
`timescale 1ns/1ps
// Charge parameter and timer control registers with watchdog and safety timer
module cptr_regs
    import cptr_pkg::*;
#(
    parameter int TICK_CYC = CPTR_TICK_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       link_access,
    input  wire logic       fast_charge,
    input  wire logic       timer_slowdown_enable,
    input  wire logic       dpm_active,
    input  wire logic       thermal_reg_active,
    input  wire logic       termination_current_reached,
    input  wire logic       below_800ma,
    output logic [7:0]      reg_rdata,
    output logic [5:0]      charge_voltage_code,
    output logic            precharge_threshold_sel,
    output logic            recharge_offset_sel,
    output logic            term_enable,
    output logic            charge_done_ind,
    output logic            wd_fault,
    output logic [1:0]      charge_fault_field
);
    logic [7:0]  vctrl_r;
    logic [7:0]  tctrl_r;
    logic [23:0] div_r;
    logic        fc_d_r;
    logic        wd_exp;
    logic        tmr_exp;

    wire        tick      = (div_r == 24'(TICK_CYC - 1));
    wire        wr_v      = reg_wr && (reg_addr == CPTR_OFS_VCTRL);
    wire        wr_t      = reg_wr && (reg_addr == CPTR_OFS_TCTRL);
    wire [1:0]  wd_sel    = tctrl_r[CPTR_WD_HI:CPTR_WD_LO];
    wire [1:0]  lim_sel   = tctrl_r[CPTR_TLIM_HI:CPTR_TLIM_LO];
    wire        tmr_en    = tctrl_r[CPTR_TMR_BIT];
    wire        fc_start  = fast_charge && !fc_d_r;
    wire [16:0] wd_lim    = (wd_sel == 2'h1) ? 17'(CPTR_WD_S0) :
                            (wd_sel == 2'h2) ? 17'(CPTR_WD_S1) : 17'(CPTR_WD_S2);
    wire [16:0] tmr_lim   = (lim_sel == 2'h0) ? 17'(CPTR_LIM_H0 * CPTR_HR_S) :
                            (lim_sel == 2'h1) ? 17'(CPTR_LIM_H1 * CPTR_HR_S) :
                            (lim_sel == 2'h2) ? 17'(CPTR_LIM_H2 * CPTR_HR_S) : 17'(CPTR_LIM_H3 * CPTR_HR_S);
    wire        slow      = timer_slowdown_enable && (dpm_active || thermal_reg_active);
    wire        done_nxt  = tctrl_r[CPTR_EARLY_BIT] ? below_800ma : termination_current_reached;
    wire [7:0]  rdata_nxt = (reg_addr == CPTR_OFS_VCTRL) ? vctrl_r :
                            (reg_addr == CPTR_OFS_TCTRL) ? tctrl_r :
                            (reg_addr == CPTR_OFS_FAULT) ? {2'h0, charge_fault_field, 4'h0} : 8'h00;

    // Watchdog expiry restores defaults so a silent host cannot leave odd settings
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            vctrl_r <= CPTR_RST_VCTRL;
            tctrl_r <= CPTR_RST_TCTRL;
        end else if (wd_exp) begin
            vctrl_r <= CPTR_RST_VCTRL;
            tctrl_r <= CPTR_RST_TCTRL;
        end else begin
            if (wr_v)
                vctrl_r <= reg_wdata;
            if (wr_t)
                tctrl_r <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            div_r  <= '0;
            fc_d_r <= 1'b0;
        end else begin
            div_r  <= tick ? 24'h000000 : div_r + 24'h000001;
            fc_d_r <= fast_charge;
        end
    end

    cptr_sec_counter #(.W(17)) u_wd (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .tick    (tick),
        .run     (wd_sel != 2'h0),
        .clear   (link_access || wd_exp || reg_wr || reg_rd),
        .half    (1'b0),
        .limit   (wd_lim),
        .expired (wd_exp)
    );

    cptr_sec_counter #(.W(17)) u_tmr (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .tick    (tick),
        .run     (tmr_en && fast_charge),
        .clear   (fc_start || !tmr_en),
        .half    (slow),
        .limit   (tmr_lim),
        .expired (tmr_exp)
    );

    // Outputs registered; the fault code stays until a new fast-charge phase
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            reg_rdata               <= 8'h00;
            charge_voltage_code     <= CPTR_RST_VCTRL[CPTR_VCODE_HI:CPTR_VCODE_LO];
            precharge_threshold_sel <= 1'b0;
            recharge_offset_sel     <= 1'b0;
            term_enable             <= 1'b0;
            charge_done_ind         <= 1'b0;
            wd_fault                <= 1'b0;
            charge_fault_field      <= 2'h0;
        end else begin
            if (reg_rd)
                reg_rdata <= rdata_nxt;
            charge_voltage_code     <= vctrl_r[CPTR_VCODE_HI:CPTR_VCODE_LO];
            precharge_threshold_sel <= vctrl_r[CPTR_PRE_BIT];
            recharge_offset_sel     <= vctrl_r[CPTR_RCH_BIT];
            term_enable             <= tctrl_r[CPTR_TERM_BIT];
            charge_done_ind         <= done_nxt;
            if (wd_exp)
                wd_fault <= 1'b1;
            else if (reg_rd && reg_addr == CPTR_OFS_FAULT)
                wd_fault <= 1'b0;
            if (tmr_exp)
                charge_fault_field <= CPTR_FAULT_TMR;
            else if (fc_start)
                charge_fault_field <= 2'h0;
        end
    end
endmodule

//--- tb/cptr_regs_asserts.sv
// Checker for the charge parameter and timer registers
`timescale 1ns/1ps
module cptr_regs_asserts
    import cptr_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       fast_charge,
    input wire logic [7:0] reg_rdata,
    input wire logic [5:0] charge_voltage_code,
    input wire logic       precharge_threshold_sel,
    input wire logic       recharge_offset_sel,
    input wire logic       term_enable,
    input wire logic [1:0] charge_fault_field
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    sequence s_wr(logic [7:0] ofs);
        reg_wr && reg_addr == ofs;
    endsequence
    a_code_follow: assert property (s_wr(CPTR_OFS_VCTRL) |-> ##2
        {charge_voltage_code, precharge_threshold_sel, recharge_offset_sel} == $past(reg_wdata, 2))
        else $error("voltage fields do not follow write");
    a_term_follow: assert property (s_wr(CPTR_OFS_TCTRL) |-> ##2 term_enable == $past(reg_wdata[7], 2))
        else $error("termination enable does not follow write");
    a_fault_read: assert property (reg_rd && reg_addr == CPTR_OFS_FAULT |=>
        reg_rdata[5:4] == $past(charge_fault_field)) else $error("fault field read wrong");
    a_fault_code: assert property (charge_fault_field != 2'h0 |-> charge_fault_field == CPTR_FAULT_TMR)
        else $error("unexpected fault code");
    a_fault_clear: assert property ($rose(fast_charge) |-> ##[1:2] charge_fault_field == 2'h0)
        else $error("fault not cleared on new fast charge");
    a_reset_term: assert property ($rose(resetn) |=> term_enable)
        else $error("termination not enabled after reset");
    a_unmapped_zero: assert property (reg_rd && reg_addr > CPTR_OFS_FAULT |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_stand: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without read");
endmodule

bind cptr_regs cptr_regs_asserts u_chk (.clk_sys, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .fast_charge,
    .reg_rdata, .charge_voltage_code, .precharge_threshold_sel, .recharge_offset_sel, .term_enable,
    .charge_fault_field);

//--- tb/cptr_host.sv
// Host model that issues register accesses and link activity
`timescale 1ns/1ps
module cptr_host (
    input  wire logic       clk_sys,
    input  wire logic [7:0] reg_rdata,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            link_access
);
    initial begin
        {reg_wr, reg_rd, link_access, reg_addr, reg_wdata} = 19'h0;
    end
    // Every access restarts the watchdog, so settings survive busy periods
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] dw, output logic [7:0] d);
        @(posedge clk_sys);
        {reg_wr, reg_rd} <= {w, !w};
        reg_addr <= a;
        reg_wdata <= dw;
        @(posedge clk_sys);
        {reg_wr, reg_rd} <= 2'h0;
        reg_wdata <= ~dw;
        #1 d = reg_rdata;
    endtask
    task automatic ping();
        @(posedge clk_sys);
        link_access <= 1'b1;
        @(posedge clk_sys);
        link_access <= 1'b0;
    endtask
endmodule

//--- tb/test_cptr_regs.sv
// Self-checking bench for the charge parameter and timer registers
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module test_cptr_regs
    import cptr_pkg::*;
;
    logic       clk_sys = 0, resetn = 0, fast_charge = 0, termination_current_reached = 0, below_800ma = 0;
    logic       reg_wr, reg_rd, link_access, pre_sel, rch_sel, term_enable, done_ind, wd_fault;
    logic       timer_slowdown_enable = 0, dpm_active = 0, thermal_reg_active = 0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d, v;
    logic [5:0] vcode;
    logic [1:0] fault;
    int         checks = 0, miscompares = 0;
    always #50 clk_sys = ~clk_sys;
    cptr_regs #(.TICK_CYC(2)) DUT (.clk_sys, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .link_access,
        .fast_charge, .timer_slowdown_enable, .dpm_active, .thermal_reg_active,
        .termination_current_reached, .below_800ma, .reg_rdata, .charge_voltage_code(vcode), .precharge_threshold_sel(pre_sel),
        .recharge_offset_sel(rch_sel), .term_enable, .charge_done_ind(done_ind), .wd_fault,
        .charge_fault_field(fault));
    cptr_host host (.clk_sys, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .link_access);
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        host.acc(1'b1, a, x, d);
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host.acc(1'b0, a, 8'h00, d);
        `CHK(d, e)
    endtask
    task automatic tally_and_finish();
        if (miscompares == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic t_fields();
        for (int i = 0; i < 4; i++) begin
            v = {i[0], i[1], i[1:0], i[0], i[1:0], 1'b0};
            wr(CPTR_OFS_TCTRL, v);
            rdchk(CPTR_OFS_TCTRL, v);
            `CHK(term_enable, v[7])
            v = (i == 0) ? 8'h3c : {v[1:0], v[7:2]} ^ 8'hc3;
            wr(CPTR_OFS_VCTRL, v);
            `CHK({vcode, pre_sel, rch_sel}, v)
        end
    endtask
    task automatic t_early();
        wr(CPTR_OFS_TCTRL, 8'hc0);
        below_800ma <= 1'b1;
        wr(CPTR_OFS_TCTRL, 8'hc0);
        `CHK(done_ind, 1'b1)
        wr(CPTR_OFS_TCTRL, 8'h80);
        `CHK(done_ind, 1'b0)
        termination_current_reached <= 1'b1;
        below_800ma <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        `CHK(done_ind, 1'b1)
        termination_current_reached <= 1'b0;
    endtask
    task automatic t_watchdog();
        wr(CPTR_OFS_TCTRL, 8'h9a);
        wr(CPTR_OFS_VCTRL, 8'h00);
        repeat (60) @(posedge clk_sys);
        host.ping();
        repeat (60) @(posedge clk_sys);
        rdchk(CPTR_OFS_VCTRL, 8'h00);
        repeat (100) @(posedge clk_sys);
        `CHK(wd_fault, 1'b1)
        rdchk(CPTR_OFS_VCTRL, CPTR_RST_VCTRL);
        rdchk(CPTR_OFS_FAULT, 8'h00);
        `CHK(wd_fault, 1'b0)
    endtask
    task automatic t_safety();
        wr(CPTR_OFS_TCTRL, 8'h80);
        fast_charge <= 1'b1;
        repeat (20000) @(posedge clk_sys);
        `CHK(fault, 2'h0)
        wr(CPTR_OFS_TCTRL, 8'h88);
        // Half rate for 4000 cycles costs 2000 cycles of extra run time
        timer_slowdown_enable <= 1'b1;
        dpm_active <= 1'b1;
        repeat (2000) @(posedge clk_sys);
        dpm_active <= 1'b0;
        thermal_reg_active <= 1'b1;
        repeat (2000) @(posedge clk_sys);
        thermal_reg_active <= 1'b0;
        timer_slowdown_enable <= 1'b0;
        repeat (33960) @(posedge clk_sys);
        `CHK(fault, 2'h0)
        `CHK(fault, 2'h0)
        repeat (80) @(posedge clk_sys);
        rdchk(CPTR_OFS_FAULT, 8'h30);
        fast_charge <= 1'b0;
        wr(CPTR_OFS_TCTRL, 8'h88);
        fast_charge <= 1'b1;
        wr(CPTR_OFS_TCTRL, 8'h88);
        `CHK(fault, 2'h0)
    endtask
    initial begin
        #10ms;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        rdchk(CPTR_OFS_TCTRL, CPTR_RST_TCTRL);
        rdchk(8'h0c, 8'h00);
        t_fields();
        t_early();
        t_watchdog();
        t_safety();
        tally_and_finish();
    end
endmodule
